// ### rtl/lsa_consts.svh
// Purpose: constants for the light sensor converter serial slave
// Assumes: included by bare name from rtl/
// Notes:   commands, address and timing counts as macros
`ifndef LSA_CONSTS_SVH
`define LSA_CONSTS_SVH

// slave address: four fixed upper bits, three from select pins
`define LSA_ADDR_HI      4'h8
// command codes
`define LSA_CMD_PD       8'h8c
`define LSA_CMD_RST      8'h0c
`define LSA_CMD_INT_D1   8'h00
`define LSA_CMD_INT_D2   8'h04
`define LSA_CMD_INT_DIFF 8'h08
`define LSA_CMD_EXT_D1   8'h30
`define LSA_CMD_EXT_D2   8'h34
`define LSA_CMD_EXT_DIFF 8'h38
`define LSA_CMD_RESET    8'h00
// bytes returned on a read before the device stops driving
`define LSA_INT_BYTES    3'h2
`define LSA_EXT_BYTES    3'h4
// last oscillator cycle index of an internally timed period
`define LSA_INT_LAST     16'h7fff
`define LSA_INT_LAST_DIF 16'hffff
// byte sent when no data is available (line left released)
`define LSA_IDLE_BYTE    8'hff

`endif

// ### rtl/lsa_pkg.sv
// Purpose: types shared by the light sensor converter serial slave
// Assumes: nothing
// Notes:   serial slave state machine is one-hot
package lsa_pkg;

  typedef enum logic [6:0] {
    LSA_ST_IDLE = 7'h01,
    LSA_ST_ADDR = 7'h02,
    LSA_ST_AACK = 7'h04,
    LSA_ST_WR   = 7'h08,
    LSA_ST_WACK = 7'h10,
    LSA_ST_RD   = 7'h20,
    LSA_ST_RACK = 7'h40
  } lsa_st_e;

  typedef enum logic [1:0] {
    LSA_SEL_D1   = 2'h0,
    LSA_SEL_D2   = 2'h1,
    LSA_SEL_DIFF = 2'h2
  } lsa_sel_e;

endpackage

// ### rtl/lsa_top.sv
// Purpose: serial slave, command register and integrating converter logic
// Assumes: scl/sda/address pins are asynchronous; diode pulses are
//          synchronous to osc_clk (modulator clocked by the oscillator)
// Notes:   serial side on ref_clk, converter on osc_clk; toggle crossings
`timescale 1ns/1ns
`include "lsa_consts.svh"

// Summary of operation
// - pulses counted by binary counter; 2^16 external, 2^15 internal
// - internal timing self-times each conversion over 2^15 oscillator cycles, 2^16 in difference mode
// - single-diode modes integrate only that diode, unsigned 16-bit
// - internal difference mode integrates diode 2 then diode 1, external both at once; reports d1 minus d2
// - one 8-bit command register; behaviour holds until rewritten
// - four data bytes: two result bytes, two cycle count bytes
// - slave address is 1000 plus three select pins, 40h to 47h
// - receiver of a byte pulls data low during its acknowledge
// - every written byte replaces the command; no sub-address
// - address-write then command byte starts execution, results stored
// - read during conversion returns previously stored result
// - address-write without data re-executes the held command
// - read order: result low, result high, count low, count high
// - each external command ends a running external integration and starts the next
// - command 8c powers down; any later command wakes it
// - command 0c clears result and cycle count to zero
// - 00, 04, 08 select internal diode 1, diode 2, difference
// - 30, 34, 38 select external diode 1, diode 2, difference
// - test command with top bit set reads back the written value
// - internal modes: no data driven after two result bytes
// - cycle counter cleared at each period start, captured at each period end
module lsa_top
  import lsa_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output wire logic sda_o,
  output wire logic sda_oe,
  input  wire logic slave_addr_select_bit0,
  input  wire logic slave_addr_select_bit1,
  input  wire logic slave_addr_select_bit2,
  input  wire logic osc_clk,
  input  wire logic pulse_d1,
  input  wire logic pulse_d2,
  output wire logic adc_power_down
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: a change counts once stages two and three agree
  logic [2:0] scl_s_q;
  logic [2:0] sda_s_q;
  logic [2:0] a0_s_q;
  logic [2:0] a1_s_q;
  logic [2:0] a2_s_q;
  logic       scl_f_q;
  logic       sda_f_q;
  logic [2:0] addr_f_q;
  logic       scl_n;
  logic       sda_n;
  logic [2:0] addr_n;

  always_comb begin
    scl_n     = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_f_q;
    sda_n     = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_f_q;
    addr_n[0] = (a0_s_q[1] == a0_s_q[2]) ? a0_s_q[2] : addr_f_q[0];
    addr_n[1] = (a1_s_q[1] == a1_s_q[2]) ? a1_s_q[2] : addr_f_q[1];
    addr_n[2] = (a2_s_q[1] == a2_s_q[2]) ? a2_s_q[2] : addr_f_q[2];
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scl_s_q  <= 3'h7;
      sda_s_q  <= 3'h7;
      a0_s_q   <= 3'h0;
      a1_s_q   <= 3'h0;
      a2_s_q   <= 3'h0;
      scl_f_q  <= 1'b1;
      sda_f_q  <= 1'b1;
      addr_f_q <= 3'h0;
    end else if (ce) begin
      scl_s_q  <= {scl_s_q[1:0], scl_i};
      sda_s_q  <= {sda_s_q[1:0], sda_i};
      a0_s_q   <= {a0_s_q[1:0], slave_addr_select_bit0};
      a1_s_q   <= {a1_s_q[1:0], slave_addr_select_bit1};
      a2_s_q   <= {a2_s_q[1:0], slave_addr_select_bit2};
      scl_f_q  <= scl_n;
      sda_f_q  <= sda_n;
      addr_f_q <= addr_n;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  always_comb begin
    scl_rise = scl_n & ~scl_f_q;
    scl_fall = ~scl_n & scl_f_q;
    start_c  = scl_n & scl_f_q & sda_f_q & ~sda_n;
    stop_c   = scl_n & scl_f_q & ~sda_f_q & sda_n;
  end

  ////////////////////////////////////////////////////////////////////////
  // result crossing from the converter domain
  logic [15:0] res_q;
  logic [15:0] cnt_q;
  logic        done_tgl_q;
  logic [2:0]  dn_s_q;
  logic        dn_acc_q;
  logic        dn_acc_d;
  logic        dn_ev;
  logic [15:0] rd_res_q;
  logic [15:0] rd_res_d;
  logic [15:0] rd_cnt_q;
  logic [15:0] rd_cnt_d;

  // res_q/cnt_q are stable for a whole conversion after the toggle moves
  always_comb begin
    dn_ev    = (dn_s_q[1] == dn_s_q[2]) && (dn_s_q[2] != dn_acc_q);
    dn_acc_d = dn_acc_q;
    rd_res_d = rd_res_q;
    rd_cnt_d = rd_cnt_q;
    if (dn_ev) begin
      dn_acc_d = dn_s_q[2];
      rd_res_d = res_q;
      rd_cnt_d = cnt_q;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dn_s_q   <= 3'h0;
      dn_acc_q <= 1'b0;
      rd_res_q <= 16'h0000;
      rd_cnt_q <= 16'h0000;
    end else if (ce) begin
      dn_s_q   <= {dn_s_q[1:0], done_tgl_q};
      dn_acc_q <= dn_acc_d;
      rd_res_q <= rd_res_d;
      rd_cnt_q <= rd_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial slave; runs regardless of converter power-down
  lsa_st_e     st_q;
  lsa_st_e     st_d;
  logic [3:0]  bit_q;
  logic [3:0]  bit_d;
  logic [7:0]  sh_q;
  logic [7:0]  sh_d;
  logic        rw_q;
  logic        rw_d;
  logic        oe_q;
  logic        oe_d;
  logic [7:0]  cmd_q;
  logic [7:0]  cmd_d;
  logic        iss_tgl_q;
  logic        iss_tgl_d;
  logic        aw_q;
  logic        aw_d;
  logic        mack_q;
  logic        mack_d;
  logic [2:0]  idx_q;
  logic [2:0]  idx_d;
  logic [2:0]  nidx;
  logic [2:0]  limit;
  logic        test_md;
  logic [7:0]  tx;
  logic        wr_cap;
  logic        addr_ok;

  always_comb begin
    test_md = cmd_q[7] && (cmd_q != `LSA_CMD_PD);
    limit   = (test_md || cmd_q[5:4] == 2'h3) ? `LSA_EXT_BYTES
                                              : `LSA_INT_BYTES;
    nidx    = (st_q == LSA_ST_AACK) ? 3'h0
            : (idx_q[2] ? idx_q : idx_q + 3'h1);
    if (nidx >= limit)
      tx = `LSA_IDLE_BYTE;
    else if (test_md)
      tx = cmd_q;
    else begin
      case (nidx[1:0])
        2'h0:    tx = rd_res_q[7:0];
        2'h1:    tx = rd_res_q[15:8];
        2'h2:    tx = rd_cnt_q[7:0];
        default: tx = rd_cnt_q[15:8];
      endcase
    end
    addr_ok = (sh_q[7:1] == {`LSA_ADDR_HI, addr_f_q});
    wr_cap  = (st_q == LSA_ST_WR) && scl_fall && (bit_q == 4'h8)
              && !start_c && !stop_c;
  end

  always_comb begin
    st_d      = st_q;
    bit_d     = bit_q;
    sh_d      = sh_q;
    rw_d      = rw_q;
    oe_d      = oe_q;
    cmd_d     = cmd_q;
    iss_tgl_d = iss_tgl_q;
    aw_d      = aw_q;
    mack_d    = mack_q;
    idx_d     = idx_q;
    if (start_c || stop_c) begin
      // an address-only write re-runs the held command
      if (aw_q)
        iss_tgl_d = ~iss_tgl_q;
      aw_d  = 1'b0;
      oe_d  = 1'b0;
      bit_d = 4'h0;
      st_d  = start_c ? LSA_ST_ADDR : LSA_ST_IDLE;
    end else begin
      case (st_q)
        LSA_ST_ADDR: begin
          if (scl_rise && bit_q < 4'h8) begin
            sh_d  = {sh_q[6:0], sda_n};
            bit_d = bit_q + 4'h1;
          end else if (scl_fall && bit_q == 4'h8) begin
            if (addr_ok) begin
              st_d = LSA_ST_AACK;
              oe_d = 1'b1;
              rw_d = sh_q[0];
            end else begin
              st_d = LSA_ST_IDLE;
            end
          end
        end
        LSA_ST_AACK: begin
          if (scl_fall) begin
            bit_d = 4'h0;
            if (rw_q) begin
              idx_d = 3'h0;
              sh_d  = tx;
              oe_d  = ~tx[7];
              st_d  = LSA_ST_RD;
            end else begin
              oe_d = 1'b0;
              aw_d = 1'b1;
              st_d = LSA_ST_WR;
            end
          end
        end
        LSA_ST_WR: begin
          if (scl_rise && bit_q < 4'h8) begin
            sh_d  = {sh_q[6:0], sda_n};
            bit_d = bit_q + 4'h1;
          end else if (wr_cap) begin
            cmd_d     = sh_q;
            iss_tgl_d = ~iss_tgl_q;
            aw_d      = 1'b0;
            oe_d      = 1'b1;
            st_d      = LSA_ST_WACK;
          end
        end
        LSA_ST_WACK: begin
          if (scl_fall) begin
            oe_d  = 1'b0;
            bit_d = 4'h0;
            st_d  = LSA_ST_WR;
          end
        end
        LSA_ST_RD: begin
          if (scl_fall) begin
            if (bit_q == 4'h7) begin
              oe_d = 1'b0;
              st_d = LSA_ST_RACK;
            end else begin
              sh_d  = {sh_q[6:0], 1'b1};
              oe_d  = ~sh_q[6];
              bit_d = bit_q + 4'h1;
            end
          end
        end
        LSA_ST_RACK: begin
          if (scl_rise)
            mack_d = ~sda_n;
          else if (scl_fall) begin
            if (mack_q) begin
              idx_d = nidx;
              sh_d  = tx;
              oe_d  = ~tx[7];
              bit_d = 4'h0;
              st_d  = LSA_ST_RD;
            end else begin
              st_d = LSA_ST_IDLE;
            end
          end
        end
        default: begin
          oe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q      <= LSA_ST_IDLE;
      bit_q     <= 4'h0;
      sh_q      <= 8'h00;
      rw_q      <= 1'b0;
      oe_q      <= 1'b0;
      cmd_q     <= `LSA_CMD_RESET;
      iss_tgl_q <= 1'b0;
      aw_q      <= 1'b0;
      mack_q    <= 1'b0;
      idx_q     <= 3'h0;
    end else if (ce) begin
      st_q      <= st_d;
      bit_q     <= bit_d;
      sh_q      <= sh_d;
      rw_q      <= rw_d;
      oe_q      <= oe_d;
      cmd_q     <= cmd_d;
      iss_tgl_q <= iss_tgl_d;
      aw_q      <= aw_d;
      mack_q    <= mack_d;
      idx_q     <= idx_d;
    end
  end

  // open drain: the pad only ever pulls low
  assign sda_o  = 1'b0;
  assign sda_oe = oe_q;

  ////////////////////////////////////////////////////////////////////////
  // converter on the oscillator clock
  logic [1:0]  ce_s_q;
  logic [2:0]  iss_s_q;
  logic        iss_acc_q;
  logic        iss_acc_d;
  logic        iss_ev;
  logic        pd_q;
  logic        pd_d;
  logic        run_q;
  logic        run_d;
  logic        ext_q;
  logic        ext_d;
  lsa_sel_e    sel_q;
  lsa_sel_e    sel_d;
  logic [15:0] cyc_q;
  logic [15:0] cyc_d;
  logic [15:0] acc_q;
  logic [15:0] acc_d;
  logic [15:0] inc;
  logic [15:0] res_d;
  logic [15:0] cnt_d;
  logic        done_tgl_d;
  logic        mode_cmd;

  // cmd_q is held from the issue toggle until the next write, long
  // after the toggle has been seen here, so it is read directly
  always_comb begin
    iss_ev = (iss_s_q[1] == iss_s_q[2]) && (iss_s_q[2] != iss_acc_q);
    case (sel_q)
      LSA_SEL_D1: inc = {15'h0000, pulse_d1};
      LSA_SEL_D2: inc = {15'h0000, pulse_d2};
      default: begin
        // internal: first half diode 2 subtracted, second half diode 1
        if (!ext_q)
          inc = cyc_q[15] ? {15'h0000, pulse_d1}
                          : 16'h0000 - {15'h0000, pulse_d2};
        else
          inc = {15'h0000, pulse_d1} - {15'h0000, pulse_d2};
      end
    endcase
    iss_acc_d  = iss_acc_q;
    pd_d       = pd_q;
    run_d      = run_q;
    ext_d      = ext_q;
    sel_d      = sel_q;
    cyc_d      = cyc_q;
    acc_d      = acc_q;
    res_d      = res_q;
    cnt_d      = cnt_q;
    done_tgl_d = done_tgl_q;
    mode_cmd   = 1'b0;
    if (run_q) begin
      cyc_d = cyc_q + 16'h0001;
      acc_d = acc_q + inc;
      if (!ext_q && cyc_q == ((sel_q == LSA_SEL_DIFF) ? `LSA_INT_LAST_DIF
                                                    : `LSA_INT_LAST)) begin
        res_d      = acc_q + inc;
        cnt_d      = cyc_q + 16'h0001;
        done_tgl_d = ~done_tgl_q;
        acc_d      = 16'h0000;
        cyc_d      = 16'h0000;
      end
    end
    if (iss_ev) begin
      iss_acc_d = iss_s_q[2];
      pd_d      = 1'b0;
      case (cmd_q)
        `LSA_CMD_PD: begin
          pd_d  = 1'b1;
          run_d = 1'b0;
        end
        `LSA_CMD_RST: begin
          run_d      = 1'b0;
          acc_d      = 16'h0000;
          cyc_d      = 16'h0000;
          res_d      = 16'h0000;
          cnt_d      = 16'h0000;
          done_tgl_d = ~done_tgl_q;
        end
        `LSA_CMD_INT_D1, `LSA_CMD_INT_D2, `LSA_CMD_INT_DIFF,
        `LSA_CMD_EXT_D1, `LSA_CMD_EXT_D2, `LSA_CMD_EXT_DIFF: begin
          mode_cmd = 1'b1;
        end
        default: begin
          run_d = 1'b0;
        end
      endcase
      if (mode_cmd) begin
        ext_d = (cmd_q[5:4] == 2'h3);
        sel_d = lsa_sel_e'(cmd_q[3:2]);
        // an external command closes the running external period
        if (run_q && ext_q && ext_d) begin
          res_d      = acc_q;
          cnt_d      = cyc_q;
          done_tgl_d = ~done_tgl_q;
        end
        run_d = 1'b1;
        acc_d = 16'h0000;
        cyc_d = 16'h0000;
      end
    end
  end

  always_ff @(posedge osc_clk or posedge rst) begin
    if (rst) begin
      ce_s_q <= 2'h0;
    end else begin
      ce_s_q <= {ce_s_q[0], ce};
    end
  end

  always_ff @(posedge osc_clk or posedge rst) begin
    if (rst) begin
      iss_s_q    <= 3'h0;
      iss_acc_q  <= 1'b0;
      pd_q       <= 1'b0;
      run_q      <= 1'b0;
      ext_q      <= 1'b0;
      sel_q      <= LSA_SEL_D1;
      cyc_q      <= 16'h0000;
      acc_q      <= 16'h0000;
      res_q      <= 16'h0000;
      cnt_q      <= 16'h0000;
      done_tgl_q <= 1'b0;
    end else if (ce_s_q[1]) begin
      iss_s_q    <= {iss_s_q[1:0], iss_tgl_q};
      iss_acc_q  <= iss_acc_d;
      pd_q       <= pd_d;
      run_q      <= run_d;
      ext_q      <= ext_d;
      sel_q      <= sel_d;
      cyc_q      <= cyc_d;
      acc_q      <= acc_d;
      res_q      <= res_d;
      cnt_q      <= cnt_d;
      done_tgl_q <= done_tgl_d;
    end
  end

  assign adc_power_down = pd_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  AST_ADDR_MISS: assert property (@(posedge ref_clk) disable iff (rst)
    ce && st_q == LSA_ST_ADDR && scl_fall && bit_q == 4'h8 && !addr_ok
    && !start_c && !stop_c |=> st_q == LSA_ST_IDLE && !oe_q)
    else $error("foreign address was acknowledged");

  AST_ACK_LOW: assert property (@(posedge ref_clk) disable iff (rst)
    (st_q == LSA_ST_AACK || st_q == LSA_ST_WACK) |-> oe_q)
    else $error("acknowledge slot not driven low");

  AST_CMD_LOAD: assert property (@(posedge ref_clk) disable iff (rst)
    ce && wr_cap |=> cmd_q == $past(sh_q) && st_q == LSA_ST_WACK)
    else $error("written byte did not replace command");

  AST_CMD_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    !(ce && wr_cap) |=> $stable(cmd_q))
    else $error("command changed without a write");

  AST_ISSUE: assert property (@(posedge ref_clk) disable iff (rst)
    ce && (wr_cap || ((start_c || stop_c) && aw_q))
    |=> iss_tgl_q != $past(iss_tgl_q))
    else $error("command not issued to converter");

  AST_INT_TWO: assert property (@(posedge ref_clk) disable iff (rst)
    st_q == LSA_ST_RD && idx_q >= limit |-> !oe_q)
    else $error("data driven past allowed byte count");

  AST_FIRST_BYTE: assert property (@(posedge ref_clk) disable iff (rst)
    ce && st_q == LSA_ST_AACK && scl_fall && rw_q && !test_md
    && !start_c && !stop_c && !dn_ev
    |=> st_q == LSA_ST_RD && sh_q == rd_res_q[7:0])
    else $error("first read byte is not result low byte");

  AST_INT_PERIOD: assert property (@(posedge osc_clk) disable iff (rst)
    ce_s_q[1] && run_q && !ext_q && sel_q != LSA_SEL_DIFF
    && cyc_q == `LSA_INT_LAST && !iss_ev
    |=> cyc_q == 16'h0000 && cnt_q == 16'h8000
    && done_tgl_q != $past(done_tgl_q))
    else $error("internal period did not close at its last cycle");

  AST_PWR_DOWN: assert property (@(posedge osc_clk) disable iff (rst)
    ce_s_q[1] && iss_ev && cmd_q == `LSA_CMD_PD |=> pd_q && !run_q)
    else $error("power-down command ignored");

  AST_RST_CLR: assert property (@(posedge osc_clk) disable iff (rst)
    ce_s_q[1] && iss_ev && cmd_q == `LSA_CMD_RST
    |=> res_q == 16'h0000 && cnt_q == 16'h0000 && !run_q)
    else $error("reset command did not clear the readings");

  AST_RD_STABLE: assert property (@(posedge ref_clk) disable iff (rst)
    !(ce && dn_ev) |=> $stable(rd_res_q) && $stable(rd_cnt_q))
    else $error("stored reading changed before conversion end");

  COV_WRITE: cover property (@(posedge ref_clk) disable iff (rst)
    ce && wr_cap);
  COV_READ4: cover property (@(posedge ref_clk) disable iff (rst)
    st_q == LSA_ST_RD && idx_q == 3'h3);
  COV_EXT_END: cover property (@(posedge osc_clk) disable iff (rst)
    iss_ev && run_q && ext_q);
  COV_INT_END: cover property (@(posedge osc_clk) disable iff (rst)
    run_q && !ext_q && cyc_q == `LSA_INT_LAST_DIF);

endmodule

// ### dv/lsa_bus_master.sv
// Purpose: serial bus master model, drives scl and its share of sda
// Assumes: sda is the resolved open-drain wire with pull-up
// Notes:   phases of 8 ref_clk cycles suit the slave's input filter
`timescale 1ns/1ns
module lsa_bus_master (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_m
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // data moves a little after scl falls, never read as start or stop
  task automatic bit_io(input logic b, output logic s);
    tk(2);
    sda_m = b;
    tk(8);
    scl = 1'b1;
    tk(8);
    s = sda;
    scl = 1'b0;
  endtask
  task automatic start();
    tk(2);
    sda_m = 1'b1;
    tk(8);
    scl = 1'b1;
    tk(8);
    sda_m = 1'b0;
    tk(8);
    scl = 1'b0;
  endtask
  task automatic stop();
    tk(2);
    sda_m = 1'b0;
    tk(8);
    scl = 1'b1;
    tk(8);
    sda_m = 1'b1;
    tk(8);
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  // acks every byte but the last, so a read may stop early
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, s);
  endtask
endmodule

// ### dv/lsa_top_tb.sv
// Purpose: self-checking bench for the light sensor serial slave
// Assumes: pulse inputs held high give one count per oscillator cycle
// Notes:   internal periods are full length, so the run is long
`timescale 1ns/1ns
`include "lsa_consts.svh"
module lsa_top_tb;
  localparam logic [2:0] ASEL = 3'h5;
  localparam logic [7:0] ECMD [4] = '{8'h30, 8'h34, 8'h38, 8'h38};
  localparam logic [7:0] ICMD [3] = '{`LSA_CMD_INT_D1, `LSA_CMD_INT_D2,
                                      `LSA_CMD_INT_DIFF};
  logic        ref_clk = 1'b0;
  logic        osc_clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        pulse_d1 = 1'b0;
  logic        pulse_d2 = 1'b0;
  logic        scl, sda_m, sda_o, sda_oe, adc_power_down, ack;
  logic [15:0] prev, cnt;
  logic [7:0]  rd [4];
  int          err_count = 0;
  int          tests_run = 0;
  wire         sda = sda_m & (sda_oe ? sda_o : 1'b1);

  initial forever #5 ref_clk = ~ref_clk;
  initial begin
    #2;
    forever #3 osc_clk = ~osc_clk;
  end
  lsa_top DUT (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe),
    .slave_addr_select_bit0(ASEL[0]), .slave_addr_select_bit1(ASEL[1]),
    .slave_addr_select_bit2(ASEL[2]), .osc_clk(osc_clk),
    .pulse_d1(pulse_d1), .pulse_d2(pulse_d2),
    .adc_power_down(adc_power_down)
  );
  lsa_bus_master M (.clk(ref_clk), .sda(sda), .scl(scl), .sda_m(sda_m));
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic addr_phase(input logic rw);
    M.start();
    M.wr_byte({`LSA_ADDR_HI, ASEL, rw}, ack);
    chk("addr ack", 16'h1, {15'h0, ack});
  endtask
  task automatic write_cmd(input logic [7:0] c);
    addr_phase(1'b0);
    M.wr_byte(c, ack);
    chk("cmd ack", 16'h1, {15'h0, ack});
    M.stop();
  endtask
  task automatic read_n(input int n);
    addr_phase(1'b1);
    for (int i = 0; i < n; i++) begin
      M.rd_byte(i == n - 1, rd[i]);
    end
    M.stop();
  endtask
  // pulses change just after an oscillator edge, as the modulator would
  task automatic set_pulse(input logic a, input logic b);
    @(posedge osc_clk);
    #1;
    pulse_d1 = a;
    pulse_d2 = b;
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    wait_clk(90000);
    err_count++;
    wrap_up();
  end
  initial begin
    wait_clk(12);
    rst = 1'b0;
    wait_clk(10);
    M.start();
    M.wr_byte(8'h88, ack);
    chk("foreign addr ack", 16'h0, {15'h0, ack});
    M.stop();
    // a frozen slave must ignore even its own address
    ce = 1'b0;
    M.start();
    M.wr_byte({`LSA_ADDR_HI, ASEL, 1'b0}, ack);
    chk("frozen ack", 16'h0, {15'h0, ack});
    M.stop();
    ce = 1'b1;
    wait_clk(4);
    write_cmd(8'ha5);
    read_n(4);
    for (int i = 0; i < 4; i++) begin
      chk("test echo", 16'h00a5, {8'h0, rd[i]});
    end
    write_cmd(`LSA_CMD_PD);
    wait_clk(20);
    chk("power down", 16'h1, {15'h0, adc_power_down});
    read_n(1);
    chk("power down read", 16'h0, {8'h0, rd[0]});
    write_cmd(`LSA_CMD_RST);
    wait_clk(20);
    chk("wake", 16'h0, {15'h0, adc_power_down});
    read_n(2);
    chk("cleared result", 16'h0, {rd[1], rd[0]});
    set_pulse(1'b1, 1'b0);
    prev = 16'h0;
    // the difference period is twice as long, so only its early read
    for (int i = 0; i < 3; i++) begin
      write_cmd(ICMD[i]);
      read_n(3);
      chk("early result", prev, {rd[1], rd[0]});
      chk("no count byte", 16'h00ff, {8'h0, rd[2]});
      wait_clk(i == 2 ? 50 : 21000);
      read_n(2);
      prev = (i == 0) ? 16'h8000 : 16'h0;
      chk("internal result", prev, {rd[1], rd[0]});
    end
    for (int i = 0; i < 4; i++) begin
      set_pulse(i != 3, i == 3);
      write_cmd(ECMD[i]);
      wait_clk(1500);
      addr_phase(1'b0);
      M.stop();
      wait_clk(50);
      read_n(4);
      cnt = {rd[3], rd[2]};
      // 1750 bus clocks between the two commands, in oscillator cycles
      chk("count range", 16'h1,
          {15'h0, cnt > 16'h0b40 && cnt < 16'h0b86});
      chk("ext result", (i == 1) ? 16'h0 : (i == 3) ? -cnt : cnt,
          {rd[1], rd[0]});
    end
    // the last reading is nonzero, so this clear can be seen
    write_cmd(`LSA_CMD_RST);
    wait_clk(20);
    read_n(2);
    chk("reset result", 16'h0, {rd[1], rd[0]});
    wrap_up();
  end
endmodule
